/* afc_pkg.sv */
package afc_pkg;

    // =====================================================================
    // Sizes
    localparam int NUM_FILTERS = 4;
    localparam int ADDR_MSB    = 39;
    localparam int HIGH_N      = ADDR_MSB - 33;

    // =====================================================================
    // Register map, byte addresses
    localparam logic [11:0] OFS_STATUS    = 12'h010;
    localparam logic [11:0] OFS_CLEAR     = 12'h014;
    localparam logic [11:0] OFS_ACTION    = 12'h018;
    localparam logic [11:0] OFS_FAIL_BASE = 12'h020;
    localparam logic [11:0] FAIL_STRIDE   = 12'h010;
    localparam logic [11:0] OFS_LOW_SUB   = 12'h000;
    localparam logic [11:0] OFS_HIGH_SUB  = 12'h004;

    // =====================================================================
    // Field positions and reset values
    localparam int STATUS_POS  = 0;
    localparam int OVERRUN_POS = 8;
    localparam int OVERLAP_POS = 16;
    localparam logic [31:0] ACTION_RESET = 32'h0000_0000;
    localparam logic [31:0] ADDR_RESET   = 32'h0000_0000;

endpackage : afc_pkg

/* afc_capture.sv */
`timescale 1ns/1ps
module afc_capture
(
    // Clock and reset
    input  wire logic                                pclk,
    input  wire logic                                presetn,
    // APB slave
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [11:0]                         paddr,
    input  wire logic [31:0]                         pwdata,
    output logic      [31:0]                         prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    // Fault reports from the filter units
    input  wire logic [afc_pkg::NUM_FILTERS-1:0]     fail_valid,
    input  wire logic [afc_pkg::NUM_FILTERS-1:0]     fail_overlap,
    input  wire logic [afc_pkg::NUM_FILTERS*(afc_pkg::ADDR_MSB+1)-1:0] fail_addr,
    // Interrupt
    output logic                                     security_fault_irq
);

    localparam int NF = afc_pkg::NUM_FILTERS;
    localparam int AW = afc_pkg::ADDR_MSB + 1;
    localparam int HN = afc_pkg::HIGH_N;

    // =====================================================================
    // Register state
    logic [NF-1:0] status;
    logic [NF-1:0] overrun;
    logic [NF-1:0] overlap;
    logic [31:0]   action;
    logic [31:0]   addr_low [NF];
    logic [HN:0]   addr_high [NF];
    logic [NF-1:0] clear_hit;
    logic          wr_access;
    logic          rd_access;
    logic [31:0]   next_prdata;
    logic          next_pslverr;
    logic          hit_status;
    logic          hit_clear;
    logic          hit_action;
    logic [NF-1:0] hit_low;
    logic [NF-1:0] hit_high;

    // The slave answers in the first access cycle, so pready is one on the access phase.
    assign wr_access = psel && penable && pwrite && pready;
    assign rd_access = psel && !penable && !pwrite;

    // One decode per register, shared by the write strobes, the read mux and the checks.
    assign hit_status = paddr == afc_pkg::OFS_STATUS;
    assign hit_clear  = paddr == afc_pkg::OFS_CLEAR;
    assign hit_action = paddr == afc_pkg::OFS_ACTION;

    // Clear pulses exist only for the configured filters; upper bits are dropped.
    assign clear_hit = (wr_access && hit_clear) ? pwdata[NF-1:0] : '0;

    function automatic logic [31:0] fail_reg_ofs(input int idx, input logic [11:0] sub);
        fail_reg_ofs = {20'h0_0000, afc_pkg::OFS_FAIL_BASE + afc_pkg::FAIL_STRIDE * idx[11:0] + sub};
    endfunction : fail_reg_ofs

    // =====================================================================
    // Per-filter capture
    genvar g;
    generate
        for (g = 0; g < NF; g++)
        begin : gen_filter
            assign hit_low[g]  = {20'h0_0000, paddr} == fail_reg_ofs(g, afc_pkg::OFS_LOW_SUB);
            assign hit_high[g] = {20'h0_0000, paddr} == fail_reg_ofs(g, afc_pkg::OFS_HIGH_SUB);

            // The three flags share one process so that a clear and a failure in one cycle resolve in one place.
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    status[g]  <= 1'b0;
                    overrun[g] <= 1'b0;
                    overlap[g] <= 1'b0;
                end
                else if (fail_valid[g])
                begin
                    // A failure arriving with a clear wins so the event is not lost.
                    status[g]  <= 1'b1;
                    overrun[g] <= (status[g] && !clear_hit[g]) || (overrun[g] && !clear_hit[g]);
                    overlap[g] <= fail_overlap[g] || (overlap[g] && !clear_hit[g]);
                end
                else if (clear_hit[g])
                begin
                    status[g]  <= 1'b0;
                    overrun[g] <= 1'b0;
                    overlap[g] <= 1'b0;
                end
            end

            // The address loads only on a recorded failure, so software always reads the first one.
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    addr_low[g]  <= afc_pkg::ADDR_RESET;
                    addr_high[g] <= '0;
                end
                else if (fail_valid[g] && (!status[g] || clear_hit[g]))
                begin
                    addr_low[g]  <= fail_addr[g*AW +: 32];
                    addr_high[g] <= fail_addr[g*AW+32 +: HN+1];
                end
            end

            // A failure that finds the flag clear is the one that gets recorded.
            sequence s_first_fail;
                fail_valid[g] && !status[g];
            endsequence

            sequence s_repeat_fail;
                fail_valid[g] && status[g] && !clear_hit[g];
            endsequence

            a_first_only_a: assert property (@(posedge pclk) disable iff (!presetn)
                status[g] && !clear_hit[g] |=> $stable(addr_low[g]) && $stable(addr_high[g]))
                else $error("Captured address changed while status was set.");

            a_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
                s_first_fail |=> addr_low[g] == $past(fail_addr[g*AW +: 32]) && status[g])
                else $error("First failure address not captured.");

            a_high_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
                s_first_fail |=> addr_high[g] == $past(fail_addr[g*AW+32 +: HN+1]))
                else $error("First failure upper address not captured.");

            a_first_no_overrun_a: assert property (@(posedge pclk) disable iff (!presetn)
                s_first_fail |=> !overrun[g])
                else $error("Overrun flagged on a first failure.");

            a_overrun_a: assert property (@(posedge pclk) disable iff (!presetn)
                s_repeat_fail |=> overrun[g])
                else $error("Overrun not flagged on second failure.");

            a_overrun_needs_status_a: assert property (@(posedge pclk) disable iff (!presetn)
                overrun[g] |-> status[g])
                else $error("Overrun set without status.");

            a_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
                clear_hit[g] && !fail_valid[g] |=> !status[g] && !overrun[g] && !overlap[g])
                else $error("Clear did not clear the flags.");

            // Zero bits in a clear write, and every read, must leave the flags alone.
            a_zero_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
                !clear_hit[g] && !fail_valid[g]
                |=> $stable(status[g]) && $stable(overrun[g]) && $stable(overlap[g]))
                else $error("Flags changed without a failure or a clear.");

            a_status_set_a: assert property (@(posedge pclk) disable iff (!presetn)
                fail_valid[g] |=> status[g])
                else $error("Status not set by a failure.");

            a_overlap_set_a: assert property (@(posedge pclk) disable iff (!presetn)
                fail_valid[g] && fail_overlap[g] |=> overlap[g])
                else $error("Overlap not flagged by an overlap failure.");

            // Neighbouring filters fail in the same cycle, so each one must see only its own slice.
            a_isolate_a: assert property (@(posedge pclk) disable iff (!presetn)
                !fail_valid[g] |=> $stable(addr_low[g]) && $stable(addr_high[g]))
                else $error("Captured address changed with no failure in this filter.");

            a_low_readback_a: assert property (@(posedge pclk) disable iff (!presetn)
                psel && !penable && !pwrite && hit_low[g] |=> prdata == $past(addr_low[g]))
                else $error("Lower fault address read back wrong.");

            // The bits above the upper field are reserved and read zero.
            a_high_readback_a: assert property (@(posedge pclk) disable iff (!presetn)
                psel && !penable && !pwrite && hit_high[g] |=> prdata == {{(31-HN){1'b0}}, $past(addr_high[g])})
                else $error("Upper fault address read back wrong.");
        end
    endgenerate

    // =====================================================================
    // Action register enables the interrupt per filter; capture ignores it.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            action <= afc_pkg::ACTION_RESET;
        else if (wr_access && hit_action)
            action <= {{(32-NF){1'b0}}, pwdata[NF-1:0]};
    end

    // The output is registered, so it trails the status by one cycle; it rises on the same edge that first registers the flag into read data.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            security_fault_irq <= 1'b0;
        else
            security_fault_irq <= |(status & action[NF-1:0]);
    end

    // =====================================================================
    // APB read path, decoded in setup so data is registered for the access phase.
    always_comb
    begin
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b0;
        if (hit_status)
            next_prdata = ({{(32-NF){1'b0}}, status} << afc_pkg::STATUS_POS)
                        | ({{(32-NF){1'b0}}, overrun} << afc_pkg::OVERRUN_POS)
                        | ({{(32-NF){1'b0}}, overlap} << afc_pkg::OVERLAP_POS);
        else if (hit_clear)
            next_prdata = 32'h0000_0000;
        else if (hit_action)
            next_prdata = action;
        else
        begin
            next_pslverr = 1'b1;
            for (int i = 0; i < NF; i++)
            begin
                if (hit_low[i])
                begin
                    next_prdata  = addr_low[i];
                    next_pslverr = 1'b0;
                end
                if (hit_high[i])
                begin
                    next_prdata  = {{(31-HN){1'b0}}, addr_high[i]};
                    next_pslverr = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            if (rd_access)
            begin
                prdata  <= next_prdata;
                pslverr <= next_pslverr;
            end
            else if (psel && !penable)
            begin
                prdata  <= 32'h0000_0000;
                pslverr <= next_pslverr && !hit_clear;
            end
        end
    end

    // =====================================================================
    // Bus and interrupt checks
    sequence s_clear_read_setup;
        psel && !penable && !pwrite && hit_clear;
    endsequence

    sequence s_read_access;
        psel && penable && !pwrite && pready;
    endsequence

    a_clear_reads_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_clear_read_setup |=> prdata == 32'h0000_0000 && pready)
        else $error("Clear register read returned nonzero.");

    // Reading the clear register must never act as a clear.
    a_clear_read_pure_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_clear_read_setup ##1 s_read_access |=> status == ($past(status) | $past(fail_valid)))
        else $error("Clear register read changed the status.");

    a_apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready)
        else $error("No answer in the access phase.");

    a_pready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("Ready held for more than one cycle.");

    a_unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && next_pslverr |=> pslverr && prdata == 32'h0000_0000)
        else $error("Unmapped read not refused.");

    a_write_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && pwrite && next_pslverr |=> pslverr)
        else $error("Unmapped write not refused.");

    a_status_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && hit_status |=> prdata[NF-1:0] == $past(status))
        else $error("Status read back wrong.");

    a_action_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && hit_action |=> action[NF-1:0] == $past(pwdata[NF-1:0]))
        else $error("Action write did not land.");

    // The enable gates only the output; the flags are checked above without it.
    a_irq_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        |(status & action[NF-1:0]) |=> security_fault_irq)
        else $error("Interrupt not raised for an enabled filter.");

    a_irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(|(status & action[NF-1:0])) |=> !security_fault_irq)
        else $error("Interrupt raised with no enabled filter set.");

endmodule : afc_capture

/* afc_fault_src.sv */
`timescale 1ns/1ps
module afc_fault_src
(
    // Clock
    input  wire logic                                                pclk,
    // Fault reports toward the capture block
    output logic [afc_pkg::NUM_FILTERS-1:0]                          fail_valid,
    output logic [afc_pkg::NUM_FILTERS-1:0]                          fail_overlap,
    output logic [afc_pkg::NUM_FILTERS*(afc_pkg::ADDR_MSB+1)-1:0]    fail_addr
);
    initial
    begin
        fail_valid   = '0;
        fail_overlap = '0;
        fail_addr    = '0;
    end

    // One failure pulse per filter in the mask; the address is inverted afterwards so stale values never match.
    task automatic inject(input logic [afc_pkg::NUM_FILTERS-1:0] m, input logic [afc_pkg::NUM_FILTERS-1:0] ov,
                          input logic [afc_pkg::NUM_FILTERS*(afc_pkg::ADDR_MSB+1)-1:0] a);
        @(posedge pclk);
        fail_valid   <= m;
        fail_overlap <= ov;
        fail_addr    <= a;
        @(posedge pclk);
        fail_valid   <= '0;
        fail_overlap <= '0;
        fail_addr    <= ~a;
    endtask : inject
endmodule : afc_fault_src

/* tb.sv */
`timescale 1ns/1ps
module tb;
    // =====================================================================
    // Signals and model state
    localparam int NF = afc_pkg::NUM_FILTERS;
    localparam int AW = afc_pkg::ADDR_MSB + 1;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, security_fault_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed;
    logic [NF-1:0] fail_valid, fail_overlap, e_st, e_ov, e_ol, act;
    logic [NF*AW-1:0] fail_addr;
    logic [31:0] e_lo[NF], e_hi[NF];
    int miscompares, tests_run;

    afc_fault_src i_afc_fault_src (.pclk(pclk), .fail_valid(fail_valid), .fail_overlap(fail_overlap),
                                   .fail_addr(fail_addr));
    afc_capture i_afc_capture (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
                               .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
                               .pslverr(pslverr), .fail_valid(fail_valid), .fail_overlap(fail_overlap),
                               .fail_addr(fail_addr), .security_fault_irq(security_fault_irq));

    always #25 pclk = ~pclk;

    // =====================================================================
    // Tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        tests_run++;
        if (g !== x)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, g, x);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (n >= 16)
            chk(32'h0, 32'h1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic fault(input logic [NF-1:0] m);
        logic [NF*AW-1:0] a;
        a = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
        i_afc_fault_src.inject(m, m & a[NF-1:0], a);
        e_ol |= m & a[NF-1:0];
        for (int i = 0; i < NF; i++)
            if (m[i] && e_st[i])
                e_ov[i] = 1'b1;
            else if (m[i])
            begin
                e_lo[i] = a[i*AW +: 32];
                e_hi[i] = 32'(a[i*AW+32 +: afc_pkg::HIGH_N+1]);
                e_st[i] = 1'b1;
            end
    endtask : fault

    function automatic logic [31:0] exp_status();
        exp_status = (32'(e_st) << afc_pkg::STATUS_POS) | (32'(e_ov) << afc_pkg::OVERRUN_POS)
                   | (32'(e_ol) << afc_pkg::OVERLAP_POS);
    endfunction : exp_status

    task automatic check_all();
        logic [31:0] d;
        logic e;
        apb(1'b0, afc_pkg::OFS_STATUS, 32'h0, d, e);
        chk(d, exp_status());
        for (int i = 0; i < NF; i++)
        begin
            apb(1'b0, afc_pkg::OFS_FAIL_BASE + 12'(i) * afc_pkg::FAIL_STRIDE, 32'h0, d, e);
            chk(d, e_lo[i]);
            apb(1'b0, afc_pkg::OFS_FAIL_BASE + 12'(i) * afc_pkg::FAIL_STRIDE + afc_pkg::OFS_HIGH_SUB, 32'h0, d, e);
            chk(d, e_hi[i]);
        end
        apb(1'b0, afc_pkg::OFS_CLEAR, 32'h0, d, e);
        chk(d, 32'h0);
        apb(1'b0, afc_pkg::OFS_ACTION, 32'h0, d, e);
        chk(d, 32'(act));
        apb(1'b0, 12'hffc, 32'h0, d, e);
        chk({31'h0, e}, 32'h1);
        chk({31'h0, security_fault_irq}, {31'h0, |(e_st & act)});
    endtask : check_all

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    // =====================================================================
    // Main sequence and watchdog
    initial
    begin
        logic [31:0] v, d;
        logic e;
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {e_st, e_ov, e_ol, act, miscompares, tests_run} = '0;
        seed = 32'h587e10ea;
        foreach (e_lo[i])
            {e_lo[i], e_hi[i]} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        check_all();
        // Every filter at once, then a repeat on filter 0 and a clear of zeros, which must change nothing.
        fault('1);
        fault(4'h1);
        apb(1'b1, afc_pkg::OFS_CLEAR, 32'h0, d, e);
        check_all();
        repeat (80)
        begin
            v = $random(seed);
            if (v[1:0] == 2'd0)
                fault(v[NF+1:2]);
            else if (v[1:0] == 2'd1)
            begin
                apb(1'b1, afc_pkg::OFS_ACTION, v, d, e);
                act = v[NF-1:0];
            end
            else
            begin
                apb(1'b1, afc_pkg::OFS_CLEAR, v, d, e);
                e_st &= ~v[NF-1:0];
                e_ov &= ~v[NF-1:0];
                e_ol &= ~v[NF-1:0];
            end
            check_all();
        end
        summarize();
    end

    initial
    begin
        #(50 * 40000);
        miscompares++;
        summarize();
    end
endmodule : tb
